// >>> rtl/instruction_operand_decoder_map.vh
// Field positions, class codes and opcode groupings for the operand decoder
`ifndef INSTRUCTION_OPERAND_DECODER_MAP_VH
`define INSTRUCTION_OPERAND_DECODER_MAP_VH

// ****************************************
// Word layout
// ****************************************
`define WORD_W            24
`define OPC_HI            23
`define OPC_LO            16
`define OPC_W             8

// ****************************************
// Class codes
// ****************************************
`define CLASS_W           3
`define CLASS_WORD_BYTE   3'h0
`define CLASS_BIT         3'h1
`define CLASS_LITERAL     3'h2
`define CLASS_DSP         3'h3
`define CLASS_CONTROL     3'h4

// ****************************************
// Opcode groups (upper nibble of the opcode)
// ****************************************
`define GRP_CTRL          4'h0
`define GRP_LIT_MOVE      4'h2
`define GRP_DEFAULT_WORKING_REGISTER_A        4'h4
`define GRP_DEFAULT_WORKING_REGISTER_B        4'h5
`define GRP_DEFAULT_WORKING_REGISTER_C        4'h6
`define GRP_DEFAULT_WORKING_REGISTER_D        4'h7
`define GRP_BIT_A         4'ha
`define GRP_LIT_ALU       4'hb
`define GRP_DSP_MAC       4'hc
`define GRP_DSP_OTHER     4'hd
`define GRP_FILE          4'he
`define GRP_BIT_B         4'hf

// Two-word opcodes (long goto, long call, double move) and table access opcodes
`define OPC_GOTO2         8'h04
`define OPC_CALL2         8'h02
`define OPC_MOVD2         8'h08
`define OPC_TBL_LO        8'hba
`define OPC_TBL_HI        8'hbb

// ****************************************
// Operand fields
// ****************************************
`define BASE_HI           14
`define BASE_LO           11
`define DMOD_HI           10
`define DMOD_LO           8
`define DST_HI            10
`define DST_LO            7
`define SMOD_HI           6
`define SMOD_LO           4
`define SRC_HI            3
`define SRC_LO            0
`define FILE_HI           12
`define FILE_LO           0
`define FILE_DIR_BIT      13
`define BITNUM_HI         15
`define BITNUM_LO         12
`define BIT_IND_BIT       11
`define BIT_FILE_BIT      7
`define LIT_HI            15
`define LIT_LO            4
`define ACC_BIT           15
`define XPF_HI            13
`define XPF_LO            12
`define YPF_HI            11
`define YPF_LO            10
`define WB_DST_HI         9
`define WB_DST_LO         8
`define SHIFT_HI          5
`define SHIFT_LO          0
`define SHIFT_REG_BIT     6
`define TBL_MODE_HI       15
`define TBL_MODE_LO       14
`define WORK0             4'h0

`endif

// >>> rtl/second_word_hold.v
// Holding register for the first half of a two-word instruction
`timescale 1ns/1ns
`include "instruction_operand_decoder_map.vh"
module second_word_hold (
    input  wire                 clk,
    input  wire                 rst,
    input  wire                 load,
    input  wire [`WORD_W-1:0]   word_in,
    output reg  [`WORD_W-1:0]   word_out
);
    always @(posedge clk) begin
        if (rst) begin
            word_out <= 24'h000000;
        end else if (load) begin
            word_out <= word_in;
        end
    end
endmodule // second_word_hold

// >>> rtl/instruction_operand_decoder.v
// Program word classifier and operand field extractor
//
// How it works
// - An ordinary instruction is one 24-bit word decoded from that word alone.
// - Three opcodes span two words and are held until the second word arrives.
// - The top 8 bits are the opcode and the rest carry operand fields.
// - Every instruction is sorted into word/byte, bit, literal, DSP or control class.
// - Working-register word/byte ops give base source, modified second source and modified destination.
// - File-register ops give a file address and a destination selector.
// - The selector sends the result to the file register or to working register zero.
// - Bit ops give a register or file target and a literal or register-held bit number.
// - Literal moves give a constant and a register or file target.
// - Literal ALU ops give a base source, a literal and a destination only if it differs.
// - MAC ops always name accumulator A or B plus operands, prefetches and write-back.
// - Other DSP ops give accumulator, modified operand and a register or literal shift.
// - Control ops give a program address and the table access mode.
`timescale 1ns/1ns
`include "instruction_operand_decoder_map.vh"
module instruction_operand_decoder (
    input  wire                 clk,
    input  wire                 rst,
    input  wire                 word_valid,
    input  wire [`WORD_W-1:0]   word,
    output reg                  insn_valid,
    output reg  [`CLASS_W-1:0]  insn_class,
    output reg  [`OPC_W-1:0]    opcode,
    output reg                  two_word,
    output reg  [`WORD_W-1:0]   second_word,
    output reg  [3:0]           base_source_register,
    output reg                  base_valid,
    output reg  [3:0]           second_source_register,
    output reg  [2:0]           second_source_mode,
    output reg                  source_valid,
    output reg  [3:0]           destination_register,
    output reg  [2:0]           destination_mode,
    output reg                  destination_valid,
    output reg  [12:0]          file_address,
    output reg                  file_valid,
    output reg                  result_to_file,
    output reg  [3:0]           bit_number,
    output reg                  bit_number_indirect,
    output reg  [15:0]          literal,
    output reg                  literal_valid,
    output reg                  accumulator_b,
    output reg  [1:0]           x_prefetch,
    output reg  [1:0]           y_prefetch,
    output reg  [1:0]           writeback_dest,
    output reg  [5:0]           shift_amount,
    output reg                  shift_by_register,
    output reg  [3:0]           shift_amount_register,
    output reg  [22:0]          program_address,
    output reg  [1:0]           table_mode
);

    // ****************************************
    // Two-word sequencing
    // ****************************************
    localparam ST_FIRST  = 1'b0;
    localparam ST_SECOND = 1'b1;

    reg                 state;
    reg                 next_state;
    wire [`WORD_W-1:0]  held_word;
    wire [`OPC_W-1:0]   opc = word[`OPC_HI:`OPC_LO];
    wire                is_long = (opc == `OPC_GOTO2) || (opc == `OPC_CALL2) ||
                                  (opc == `OPC_MOVD2);
    // A long opcode in the second slot is payload, never a new start
    wire                start_long = word_valid && (state == ST_FIRST) && is_long;

    second_word_hold second_word_hold_i (
        .clk      (clk),
        .rst      (rst),
        .load     (start_long),
        .word_in  (word),
        .word_out (held_word)
    );

    always @* begin
        next_state = state;
        case (state)
            ST_FIRST: begin
                if (start_long) begin
                    next_state = ST_SECOND;
                end
            end
            ST_SECOND: begin
                if (word_valid) begin
                    next_state = ST_FIRST;
                end
            end
            default: begin
                next_state = ST_FIRST;
            end
        endcase
    end

    // Decode always looks at the first word; second word only adds payload
    wire [`WORD_W-1:0] dw = (state == ST_SECOND) ? held_word : word;
    wire [`OPC_W-1:0]  dop = dw[`OPC_HI:`OPC_LO];
    wire [3:0]         dgrp = dop[7:4];
    wire               finish = word_valid && !start_long;

    // ****************************************
    // Classification
    // ****************************************
    reg [`CLASS_W-1:0] next_class;
    // Table access opcodes sit in the literal ALU group but count as control
    always @* begin
        case (dgrp)
            `GRP_DEFAULT_WORKING_REGISTER_A, `GRP_DEFAULT_WORKING_REGISTER_B, `GRP_DEFAULT_WORKING_REGISTER_C, `GRP_DEFAULT_WORKING_REGISTER_D, `GRP_FILE:
                next_class = `CLASS_WORD_BYTE;
            `GRP_BIT_A, `GRP_BIT_B:
                next_class = `CLASS_BIT;
            `GRP_LIT_MOVE, `GRP_LIT_ALU:
                next_class = ((dop == `OPC_TBL_LO) || (dop == `OPC_TBL_HI)) ?
                             `CLASS_CONTROL : `CLASS_LITERAL;
            `GRP_DSP_MAC, `GRP_DSP_OTHER:
                next_class = `CLASS_DSP;
            default:
                next_class = `CLASS_CONTROL;
        endcase
    end

    // ****************************************
    // Operand field helpers
    // ****************************************
    wire is_default_working_register  = (dgrp >= `GRP_DEFAULT_WORKING_REGISTER_A) && (dgrp <= `GRP_DEFAULT_WORKING_REGISTER_D);
    wire is_file  = (dgrp == `GRP_FILE);
    wire is_bit   = (next_class == `CLASS_BIT);
    wire is_lmove = (dgrp == `GRP_LIT_MOVE);
    wire is_lalu  = (next_class == `CLASS_LITERAL) && !is_lmove;
    wire is_mac   = (dgrp == `GRP_DSP_MAC);
    wire is_dsp2  = (dgrp == `GRP_DSP_OTHER);
    wire is_ctrl  = (next_class == `CLASS_CONTROL);
    wire [3:0] f_base = dw[`BASE_HI:`BASE_LO];
    wire [3:0] f_dst  = dw[`DST_HI:`DST_LO];
    wire       bit_in_file = dw[`BIT_FILE_BIT];

    // ****************************************
    // Output registers
    // ****************************************
    always @(posedge clk) begin
        if (rst) begin
            // Reset also drops a long instruction left half fetched
            state                  <= ST_FIRST;
            insn_valid             <= 1'b0;
            insn_class             <= `CLASS_CONTROL;
            opcode                 <= 8'h00;
            two_word               <= 1'b0;
            second_word            <= 24'h000000;
            base_source_register   <= 4'h0;
            base_valid             <= 1'b0;
            second_source_register <= 4'h0;
            second_source_mode     <= 3'h0;
            source_valid           <= 1'b0;
            destination_register   <= 4'h0;
            destination_mode       <= 3'h0;
            destination_valid      <= 1'b0;
            file_address           <= 13'h0000;
            file_valid             <= 1'b0;
            result_to_file         <= 1'b0;
            bit_number             <= 4'h0;
            bit_number_indirect    <= 1'b0;
            literal                <= 16'h0000;
            literal_valid          <= 1'b0;
            accumulator_b          <= 1'b0;
            x_prefetch             <= 2'h0;
            y_prefetch             <= 2'h0;
            writeback_dest         <= 2'h0;
            shift_amount           <= 6'h00;
            shift_by_register      <= 1'b0;
            shift_amount_register  <= 4'h0;
            program_address        <= 23'h000000;
            table_mode             <= 2'h0;
        end else begin
            state      <= next_state;
            insn_valid <= finish;
            // Fields move only with an answer and hold in between
            if (finish) begin
                insn_class  <= next_class;
                opcode      <= dop;
                two_word    <= (state == ST_SECOND);
                second_word <= (state == ST_SECOND) ? word : 24'h000000;
                // Base source never carries an address mode
                base_source_register <= f_base;
                base_valid   <= is_default_working_register || is_lalu || (is_bit && dw[`BIT_IND_BIT]);
                second_source_register <= dw[`SRC_HI:`SRC_LO];
                second_source_mode     <= dw[`SMOD_HI:`SMOD_LO];
                source_valid <= is_default_working_register || (is_bit && !bit_in_file) || is_dsp2 ||
                                is_mac;
                // File ops name the default working register; the selector decides
                destination_register <= is_file ? `WORK0 :
                                        (is_lmove ? dw[`SRC_HI:`SRC_LO] : f_dst);
                destination_mode     <= is_default_working_register ? dw[`DMOD_HI:`DMOD_LO] : 3'h0;
                // Literal ALU ops skip the destination when it equals the base
                destination_valid <= is_default_working_register || (is_lalu && (f_dst != f_base)) ||
                                     (is_lmove && !dw[`FILE_DIR_BIT]) ||
                                     (is_file && !dw[`FILE_DIR_BIT]);
                file_address <= dw[`FILE_HI:`FILE_LO];
                file_valid   <= is_file || (is_bit && bit_in_file) ||
                                (is_lmove && dw[`FILE_DIR_BIT]);
                result_to_file <= (is_file || is_lmove) && dw[`FILE_DIR_BIT];
                bit_number          <= dw[`BITNUM_HI:`BITNUM_LO];
                bit_number_indirect <= is_bit && dw[`BIT_IND_BIT];
                literal       <= is_lmove ? dw[19:4] : {4'h0, dw[`LIT_HI:`LIT_LO]};
                literal_valid <= is_lmove || is_lalu;
                accumulator_b <= (is_mac || is_dsp2) && dw[`ACC_BIT];
                x_prefetch     <= is_mac ? dw[`XPF_HI:`XPF_LO] : 2'h0;
                y_prefetch     <= is_mac ? dw[`YPF_HI:`YPF_LO] : 2'h0;
                writeback_dest <= is_mac ? dw[`WB_DST_HI:`WB_DST_LO] : 2'h0;
                shift_by_register     <= is_dsp2 && dw[`SHIFT_REG_BIT];
                shift_amount          <= dw[`SHIFT_HI:`SHIFT_LO];
                shift_amount_register <= dw[`SRC_HI:`SRC_LO];
                // Long forms take the upper address bits from the second word
                program_address <= (state == ST_SECOND) ?
                                   {word[6:0], dw[15:0]} : {7'h00, dw[15:0]};
                table_mode <= is_ctrl ? dw[`TBL_MODE_HI:`TBL_MODE_LO] : 2'h0;
            end
        end
    end
endmodule // instruction_operand_decoder

// >>> verification/instruction_operand_decoder_asserts.sv
// Port-level checks for the operand decoder
`timescale 1ns/1ns
`include "instruction_operand_decoder_map.vh"
module instruction_operand_decoder_asserts (
    input wire        clk,
    input wire        rst,
    input wire        word_valid,
    input wire [23:0] word,
    input wire        insn_valid,
    input wire [2:0]  insn_class,
    input wire [7:0]  opcode,
    input wire        two_word,
    input wire [23:0] second_word,
    input wire [12:0] file_address,
    input wire        result_to_file,
    input wire [3:0]  bit_number,
    input wire        accumulator_b
);
    reg        pend;
    reg [23:0] last;
    wire       is_long;
    assign is_long = word[23:16] == `OPC_GOTO2 || word[23:16] == `OPC_CALL2 || word[23:16] == `OPC_MOVD2;
    // Pending tracks a first half still waiting for its partner word
    always @(posedge clk) begin
        last <= word;
        if (rst)
            pend <= 1'b0;
        else if (word_valid)
            pend <= !pend && is_long;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    single_resp_a: assert property (word_valid && !pend && !is_long |=> insn_valid)
        else $error("single word not answered");
    long_wait_a: assert property (word_valid && !pend && is_long |=> !insn_valid)
        else $error("long first word answered early");
    long_done_a: assert property (word_valid && pend |=> insn_valid && two_word && second_word == last)
        else $error("second word not collected");
    no_spurious_a: assert property (!word_valid |=> !insn_valid)
        else $error("answer without a word");
    opcode_field_a: assert property (insn_valid && !two_word |-> opcode == last[23:16])
        else $error("opcode field wrong");
    dsp_acc_a: assert property (insn_valid && opcode[7:5] == 3'h6 |->
        insn_class == `CLASS_DSP && accumulator_b == last[`ACC_BIT]) else $error("accumulator select wrong");
    file_ops_a: assert property (insn_valid && opcode[7:4] == `GRP_FILE |->
        file_address == last[12:0] && result_to_file == last[13]) else $error("file operand wrong");
    bit_ops_a: assert property (insn_valid && insn_class == `CLASS_BIT |-> bit_number == last[15:12])
        else $error("bit number wrong");
    field_hold_a: assert property (!insn_valid |-> $stable(insn_class) && $stable(opcode))
        else $error("fields moved without an answer");
    reset_vals_a: assert property (disable iff (1'b0) rst |=> !insn_valid && insn_class == `CLASS_CONTROL)
        else $error("reset values wrong");
    long_c: cover property (insn_valid && two_word);
    dsp_c: cover property (insn_valid && insn_class == `CLASS_DSP);
    file_c: cover property (insn_valid && opcode[7:4] == `GRP_FILE);
    bit_c: cover property (insn_valid && insn_class == `CLASS_BIT);
endmodule // instruction_operand_decoder_asserts

// >>> verification/fetch_model.sv
// Fetch side model presenting program words
`timescale 1ns/1ns
module fetch_model (
    input  wire        clk,
    output reg         word_valid,
    output reg  [23:0] word
);
    initial begin
        word_valid = 1'b0;
        word       = 24'h0;
    end
    task send(input [23:0] w);
        begin
            @(posedge clk);
            word_valid <= 1'b1;
            word       <= w;
        end
    endtask
    // Idle bus changes each cycle so a stale word is never mistaken for data
    task idle;
        begin
            @(posedge clk);
            word_valid <= 1'b0;
            word       <= ~word;
        end
    endtask
endmodule // fetch_model

// >>> verification/tb_instruction_operand_decoder.sv
// Self-checking bench for the operand decoder
`timescale 1ns/1ns
`include "instruction_operand_decoder_map.vh"
`define CHK(g, e) chk(g, e)
module tb_instruction_operand_decoder;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    wire        word_valid, insn_valid, two_word;
    wire [23:0] word, second_word;
    wire [2:0]  insn_class;
    wire [7:0]  opcode;
    wire [3:0]  dst;
    wire [15:0] literal;
    wire [22:0] program_address;
    wire [1:0]  table_mode;
    wire [3:0]  base_src, src2, bit_number, shift_reg;
    wire [2:0]  src2_mode, dst_mode;
    wire [12:0] file_address;
    wire [5:0]  shift_amount;
    wire [1:0]  x_prefetch, y_prefetch, writeback_dest;
    wire        base_valid, source_valid, dst_valid, file_valid, result_to_file;
    wire        bit_ind, literal_valid, acc_b, shift_by_reg;
    wire [159:0] got;
    reg  [159:0] exp_q[$];
    integer     n_errors = 0, checks = 0, seed = 20191, i;
    reg  [23:0] r;
    reg  [7:0]  ops[0:4] = '{`OPC_GOTO2, `OPC_CALL2, `OPC_MOVD2, `OPC_TBL_LO, `OPC_TBL_HI};
    always #5 clk = ~clk;
    assign got = {23'h0, base_src, base_valid, src2, src2_mode, source_valid, dst_mode, dst_valid, file_address,
        file_valid, result_to_file, bit_number, bit_ind, literal_valid, acc_b, x_prefetch, y_prefetch,
        writeback_dest, shift_amount, shift_by_reg, shift_reg,
        insn_class, opcode, two_word, second_word, dst, literal, program_address, table_mode};
    fetch_model fetch_model_i (.clk(clk), .word_valid(word_valid), .word(word));
    instruction_operand_decoder instruction_operand_decoder_i (.clk(clk), .rst(rst), .word_valid(word_valid),
        .word(word), .insn_valid(insn_valid), .insn_class(insn_class), .opcode(opcode), .two_word(two_word),
        .second_word(second_word), .destination_register(dst), .literal(literal), .program_address(program_address),
        .table_mode(table_mode), .base_source_register(base_src), .base_valid(base_valid),
        .second_source_register(src2), .second_source_mode(src2_mode), .source_valid(source_valid),
        .destination_mode(dst_mode), .destination_valid(dst_valid), .file_address(file_address),
        .file_valid(file_valid), .result_to_file(result_to_file), .bit_number(bit_number),
        .bit_number_indirect(bit_ind), .literal_valid(literal_valid), .accumulator_b(acc_b),
        .x_prefetch(x_prefetch), .y_prefetch(y_prefetch), .writeback_dest(writeback_dest),
        .shift_amount(shift_amount), .shift_by_register(shift_by_reg), .shift_amount_register(shift_reg));
    task chk(input [159:0] g, input [159:0] e);
        begin
            checks = checks + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    function [159:0] expect_of(input [23:0] a, input [23:0] b, input tw);
        reg [3:0] g;
        reg [2:0] c;
        reg       wr, fl, bt, lm, la, mc, d2;
        begin
            g = a[23:20];
            if (a[23:16] == `OPC_TBL_LO || a[23:16] == `OPC_TBL_HI) c = `CLASS_CONTROL;
            else if ((g >= 4'h4 && g <= 4'h7) || g == 4'he) c = `CLASS_WORD_BYTE;
            else if (g == 4'ha || g == 4'hf) c = `CLASS_BIT;
            else if (g == 4'h2 || g == 4'hb) c = `CLASS_LITERAL;
            else if (g == 4'hc || g == 4'hd) c = `CLASS_DSP;
            else c = `CLASS_CONTROL;
            wr = (g >= 4'h4) && (g <= 4'h7);
            fl = (g == 4'he);
            bt = (c == `CLASS_BIT);
            lm = (g == 4'h2);
            la = (c == `CLASS_LITERAL) && !lm;
            mc = (g == 4'hc);
            d2 = (g == 4'hd);
            expect_of = {23'h0, a[14:11], wr || la || (bt && a[11]), a[3:0], a[6:4],
                wr || (bt && !a[7]) || d2 || mc, wr ? a[10:8] : 3'h0,
                wr || (la && (a[10:7] != a[14:11])) || ((lm || fl) && !a[13]),
                a[12:0], fl || (bt && a[7]) || (lm && a[13]), (fl || lm) && a[13],
                a[15:12], bt && a[11], lm || la, (mc || d2) && a[15],
                mc ? a[13:12] : 2'h0, mc ? a[11:10] : 2'h0, mc ? a[9:8] : 2'h0, a[5:0], d2 && a[6], a[3:0],
                c, a[23:16], tw, tw ? b : 24'h0, g == 4'he ? `WORK0 : g == 4'h2 ? a[3:0] : a[10:7],
                g == 4'h2 ? a[19:4] : {4'h0, a[15:4]}, tw ? b[6:0] : 7'h0, a[15:0],
                c == `CLASS_CONTROL ? a[15:14] : 2'h0};
        end
    endfunction
    task issue(input [23:0] a, input [23:0] b);
        reg tw;
        begin
            tw = a[23:16] == `OPC_GOTO2 || a[23:16] == `OPC_CALL2 || a[23:16] == `OPC_MOVD2;
            exp_q.push_back(expect_of(a, b, tw));
            fetch_model_i.send(a);
            if (tw) fetch_model_i.send(b);
        end
    endtask
    task do_reset;
        begin
            fetch_model_i.idle();
            rst <= 1'b1;
            repeat (8) @(posedge clk);
            // Cleared only while reset holds, so no late answer races it
            exp_q.delete();
            rst <= 1'b0;
        end
    endtask
    always @(posedge clk) begin
        if (!rst && insn_valid === 1'b1) begin
            if (exp_q.size() == 0) `CHK(1'b1, 1'b0);
            else `CHK(got, exp_q.pop_front());
        end
    end
    task report_and_stop;
        begin
            $display("checks %0d n_errors %0d", checks, n_errors);
            if (n_errors == 0 && checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        #100000;
        n_errors = n_errors + 1;
        report_and_stop;
    end
    initial begin
        do_reset;
        @(posedge clk);
        `CHK(insn_class, `CLASS_CONTROL);
        $display("test reset done");
        for (i = 0; i < 16; i = i + 1) begin
            r = $random(seed);
            issue({i[3:0], r[19:0]}, $random(seed));
        end
        for (i = 0; i < 5; i = i + 1) issue({ops[i], r[15:0] ^ i[15:0]}, $random(seed));
        $display("test classes done");
        for (i = 0; i < 300; i = i + 1) begin
            r = $random(seed);
            issue(r, $random(seed));
            if (r[0]) fetch_model_i.idle();
        end
        $display("test random done");
        fetch_model_i.send({`OPC_CALL2, 16'h1234});
        do_reset;
        issue(24'h4a5678, 24'h0);
        repeat (4) fetch_model_i.idle();
        `CHK(exp_q.size(), 0);
        $display("test abort done");
        report_and_stop;
    end
endmodule // tb_instruction_operand_decoder
bind instruction_operand_decoder instruction_operand_decoder_asserts instruction_operand_decoder_asserts_i (
    .clk, .rst, .word_valid, .word, .insn_valid, .insn_class, .opcode, .two_word, .second_word,
    .file_address, .result_to_file, .bit_number, .accumulator_b);
